// ### sense_wire_open_diagnostic.v
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "swo_diag_defs.vh"

// Contract
// - Force 1555h/2AAAh, mask bipolar and above-top
// - Measure forced unipolar cells only, rest off
// - Force alternate path select during scan
// - Force oversample rate zero during scan
// - Overrides last only for the scan
// - Odd scan measures cells 1..13 only
// - Even scan measures cells 2..14 only
// - Saturate at 2.5V, unmeasured no alert
// - Compare low and high thresholds, flag
// - Bipolar conversion during wire-open scans
module sense_wire_open_diagnostic
(
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        sample_valid_in,
  input  wire [3:0]  sample_chan_in,
  input  wire [13:0] sample_data_in,
  input  wire        scan_done_in,
  output reg         scan_active_out,
  output reg  [13:0] balance_switch_enable_out,
  output reg  [15:0] measure_enable_primary_out,
  output reg  [5:0]  measure_enable_aux_out,
  output reg  [15:0] diag_select_out,
  output reg         alt_path_select_out,
  output reg  [2:0]  oversample_rate_out,
  output reg         bipolar_mode_out,
  output reg         irq_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SCAN = 2'b10;

  // Mask of positions at or below top cell index
  function [13:0] below_top;
    input [3:0] top;
    integer k;
    begin
      for (k = 0; k < 14; k = k + 1)
        below_top[k] = (k <= top);
    end
  endfunction

  function is_swo_mode;
    input [2:0] cfg;
    begin
      is_swo_mode = (cfg == `SCAN_ODD_OPEN) || (cfg == `SCAN_EVEN_OPEN);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  reg rst_s1_q;
  reg rst_s2_q;
  wire rst_n = rst_s2_q;

  always @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [13:0] bal_sw_q;
  reg [15:0] meas_pri_q;
  reg [5:0]  meas_aux_q;
  reg [15:0] diag_sel_q;
  reg        alt_q;
  reg [2:0]  ovs_q;
  reg [2:0]  scan_cfg_q;
  reg [13:0] bipolar_q;
  reg [3:0]  top_cell_q;
  reg [13:0] low_thr_q;
  reg [13:0] high_thr_q;
  reg [13:0] alert_q;
  reg [13:0] last_result_q;
  reg [1:0]  irq_stat_q;
  reg [1:0]  irq_mask_q;
  reg [1:0]  state_q;
  reg [2:0]  run_cfg_q;

  wire wr_acc = psel_in && penable_in && pwrite_in;
  wire addr_ok = (paddr_in[1:0] == 2'b00) && (paddr_in <= `OFS_EFF_SCAN);
  wire start_req = wr_acc && addr_ok && (paddr_in == `OFS_SCAN_CTRL) && pwdata_in[`SCTRL_START_BIT];
  wire in_scan = (state_q == ST_SCAN);

  ////////////////////////////////////////////////////////////////////////////
  // Override computation

  wire [13:0] pattern = (run_cfg_q == `SCAN_ODD_OPEN) ? `PAT_ODD : `PAT_EVEN;
  wire [13:0] forced_sw = pattern & ~bipolar_q & below_top(top_cell_q);
  wire [13:0] forced_meas = forced_sw & ~bipolar_q;

  // Result path: saturate, compare, update measured flags only
  wire [13:0] sat_data = (sample_data_in > `RESULT_MAX) ? `RESULT_MAX : sample_data_in;
  wire        out_range = (sat_data < low_thr_q) || (sat_data > high_thr_q);
  wire        chan_ok = (sample_chan_in < 4'd14);
  wire        chan_meas = chan_ok && forced_meas[sample_chan_in];
  wire        take_sample = in_scan && sample_valid_in && chan_meas;

  wire [13:0] alert_set;
  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1)
    begin : g_alert
      assign alert_set[g] = take_sample && (sample_chan_in == g) && out_range;
    end
  endgenerate

  wire done_evt = in_scan && scan_done_in;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ST_IDLE;
      run_cfg_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_req && is_swo_mode(scan_cfg_q))
          begin
            state_q   <= ST_SCAN;
            run_cfg_q <= scan_cfg_q;
          end
        end
        ST_SCAN:
        begin
          if (scan_done_in)
            state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bal_sw_q      <= 14'h0000;
      meas_pri_q    <= 16'h0000;
      meas_aux_q    <= 6'h00;
      diag_sel_q    <= 16'h0000;
      alt_q         <= 1'b0;
      ovs_q         <= 3'h0;
      scan_cfg_q    <= 3'h0;
      bipolar_q     <= 14'h0000;
      top_cell_q    <= `RST_TOP_CELL;
      low_thr_q     <= 14'h0000;
      high_thr_q    <= `RST_HIGH_THR;
      alert_q       <= 14'h0000;
      last_result_q <= 14'h0000;
      irq_stat_q    <= 2'b00;
      irq_mask_q    <= 2'b00;
    end
    else
    begin
      if (wr_acc && addr_ok)
      begin
        case (paddr_in)
          `OFS_BAL_SW_EN:    bal_sw_q   <= pwdata_in[13:0];
          `OFS_MEAS_PRIMARY: meas_pri_q <= pwdata_in[15:0];
          `OFS_MEAS_AUX:     meas_aux_q <= pwdata_in[5:0];
          `OFS_DIAG_SEL:     diag_sel_q <= pwdata_in[15:0];
          `OFS_SCAN_CTRL:
          begin
            alt_q <= pwdata_in[`SCTRL_ALT_BIT];
            ovs_q <= pwdata_in[`SCTRL_OVS_MSB:`SCTRL_OVS_LSB];
          end
          `OFS_SCAN_CFG:     scan_cfg_q <= pwdata_in[2:0];
          `OFS_BIPOLAR:      bipolar_q  <= pwdata_in[13:0];
          `OFS_TOP_CELL:     top_cell_q <= pwdata_in[3:0];
          `OFS_LOW_THR:      low_thr_q  <= pwdata_in[13:0];
          `OFS_HIGH_THR:     high_thr_q <= pwdata_in[13:0];
          `OFS_IRQ_MASK:     irq_mask_q <= pwdata_in[1:0];
          default:           irq_mask_q <= irq_mask_q;
        endcase
      end
      // Hardware set wins over write-one-to-clear
      if (wr_acc && paddr_in == `OFS_ALERT)
        alert_q <= (alert_q & ~pwdata_in[13:0]) | alert_set;
      else
        alert_q <= alert_q | alert_set;
      if (take_sample)
        last_result_q <= sat_data;
      irq_stat_q[`IRQ_DONE_BIT] <= (irq_stat_q[`IRQ_DONE_BIT] &
        ~(wr_acc && paddr_in == `OFS_IRQ_STATUS && pwdata_in[`IRQ_DONE_BIT])) | done_evt;
      irq_stat_q[`IRQ_ALERT_BIT] <= (irq_stat_q[`IRQ_ALERT_BIT] &
        ~(wr_acc && paddr_in == `OFS_IRQ_STATUS && pwdata_in[`IRQ_ALERT_BIT])) | (|alert_set);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective configuration outputs

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scan_active_out            <= 1'b0;
      balance_switch_enable_out  <= 14'h0000;
      measure_enable_primary_out <= 16'h0000;
      measure_enable_aux_out     <= 6'h00;
      diag_select_out            <= 16'h0000;
      alt_path_select_out        <= 1'b0;
      oversample_rate_out        <= 3'h0;
      bipolar_mode_out           <= 1'b0;
      irq_out                    <= 1'b0;
    end
    else
    begin
      scan_active_out <= in_scan;
      irq_out         <= |(irq_stat_q & irq_mask_q);
      if (in_scan)
      begin
        balance_switch_enable_out  <= forced_sw;
        measure_enable_primary_out <= {2'b00, forced_meas};
        measure_enable_aux_out     <= 6'h00;
        diag_select_out            <= 16'h0000;
        alt_path_select_out        <= 1'b1;
        oversample_rate_out        <= 3'h0;
        bipolar_mode_out           <= 1'b1;
      end
      else
      begin
        balance_switch_enable_out  <= bal_sw_q;
        measure_enable_primary_out <= meas_pri_q;
        measure_enable_aux_out     <= meas_aux_q;
        diag_select_out            <= diag_sel_q;
        alt_path_select_out        <= alt_q;
        oversample_rate_out        <= ovs_q;
        bipolar_mode_out           <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read and response

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_out  <= 32'h00000000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
      prdata_out  <= 32'h00000000;
      if (psel_in && !penable_in && !pwrite_in)
      begin
        case (paddr_in)
          `OFS_BAL_SW_EN:    prdata_out <= {18'h00000, bal_sw_q};
          `OFS_MEAS_PRIMARY: prdata_out <= {16'h0000, meas_pri_q};
          `OFS_MEAS_AUX:     prdata_out <= {26'h0000000, meas_aux_q};
          `OFS_DIAG_SEL:     prdata_out <= {16'h0000, diag_sel_q};
          `OFS_SCAN_CTRL:    prdata_out <= {27'h0000000, ovs_q, alt_q, in_scan};
          `OFS_SCAN_CFG:     prdata_out <= {29'h00000000, scan_cfg_q};
          `OFS_BIPOLAR:      prdata_out <= {18'h00000, bipolar_q};
          `OFS_TOP_CELL:     prdata_out <= {28'h0000000, top_cell_q};
          `OFS_LOW_THR:      prdata_out <= {18'h00000, low_thr_q};
          `OFS_HIGH_THR:     prdata_out <= {18'h00000, high_thr_q};
          `OFS_ALERT:        prdata_out <= {18'h00000, alert_q};
          `OFS_RESULT:       prdata_out <= {18'h00000, last_result_q};
          `OFS_IRQ_STATUS:   prdata_out <= {30'h00000000, irq_stat_q};
          `OFS_IRQ_MASK:     prdata_out <= {30'h00000000, irq_mask_q};
          `OFS_EFFECTIVE:    prdata_out <= {18'h00000, balance_switch_enable_out};
          `OFS_EFF_SCAN:     prdata_out <= {27'h0000000, oversample_rate_out, alt_path_select_out, scan_active_out};
          default:           prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### sense_wire_open_diagnostic_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "swo_diag_defs.vh"
module swo_diag_chk
(
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        scan_done_in,
  input wire logic        scan_active_out,
  input wire logic [13:0] balance_switch_enable_out,
  input wire logic [15:0] measure_enable_primary_out,
  input wire logic [5:0]  measure_enable_aux_out,
  input wire logic [15:0] diag_select_out,
  input wire logic        alt_path_select_out,
  input wire logic [2:0]  oversample_rate_out,
  input wire logic        bipolar_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_done;
    scan_active_out ##0 scan_done_in;
  endsequence
  a_pready_zero_wait: assert property (s_setup |=> pready_out) else $error("pready late");
  a_pready_access: assert property (pready_out |-> psel_in && penable_in) else $error("pready stray");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0) else $error("prdata not zero");
  a_err_with_ready: assert property (pslverr_out |-> pready_out) else $error("pslverr alone");
  a_sw_pattern: assert property (scan_active_out |-> (balance_switch_enable_out & ~`PAT_ODD) == 14'h0
    || (balance_switch_enable_out & ~`PAT_EVEN) == 14'h0) else $error("switch pattern");
  a_meas_forced: assert property (scan_active_out |-> measure_enable_primary_out == {2'b00,
    balance_switch_enable_out} && measure_enable_aux_out == 6'h0 && diag_select_out == 16'h0) else $error("meas");
  a_alt_path: assert property (scan_active_out |-> alt_path_select_out) else $error("alt path");
  a_ovs_zero: assert property (scan_active_out |-> oversample_rate_out == 3'h0) else $error("ovs");
  a_bipolar_conv: assert property (scan_active_out |-> bipolar_mode_out) else $error("bipolar");
  a_scan_ends: assert property (s_done |-> ##[1:3] !scan_active_out) else $error("scan stuck");
endmodule
bind sense_wire_open_diagnostic swo_diag_chk chk_u (.clk_in, .nrst_in, .psel_in, .penable_in, .prdata_out,
  .pready_out, .pslverr_out, .scan_done_in, .scan_active_out, .balance_switch_enable_out,
  .measure_enable_primary_out, .measure_enable_aux_out, .diag_select_out, .alt_path_select_out,
  .oversample_rate_out, .bipolar_mode_out);
`default_nettype wire

// ### sense_wire_open_diagnostic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "swo_diag_defs.vh"
module sense_wire_open_diagnostic_tb;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic        sample_valid_in = 1'b0;
  logic [3:0]  sample_chan_in = 4'h0;
  logic [13:0] sample_data_in = 14'h0;
  logic        scan_done_in = 1'b0;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, scan_active_out, alt_path_select_out, bipolar_mode_out, irq_out;
  wire  [13:0] balance_switch_enable_out;
  wire  [15:0] measure_enable_primary_out, diag_select_out;
  wire  [5:0]  measure_enable_aux_out;
  wire  [2:0]  oversample_rate_out;
  wire  [63:0] eff = {7'h0, measure_enable_primary_out, diag_select_out, measure_enable_aux_out,
                      balance_switch_enable_out, alt_path_select_out, oversample_rate_out, bipolar_mode_out};
  logic [31:0] rdq;
  logic        errq;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  sense_wire_open_diagnostic dut_u (.clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .sample_valid_in, .sample_chan_in, .sample_data_in,
    .scan_done_in, .scan_active_out, .balance_switch_enable_out, .measure_enable_primary_out,
    .measure_enable_aux_out, .diag_select_out, .alt_path_select_out, .oversample_rate_out,
    .bipolar_mode_out, .irq_out);
  always #50 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("Error t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1)
        @(posedge clk_in);
      rdq = prdata_out;
      errq = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    begin
      xfer(1'b0, a, 32'h0);
      chk({32'h0, rdq}, {32'h0, e});
    end
  endtask
  task automatic smp(input logic [3:0] c, input logic [13:0] d);
    begin
      @(posedge clk_in);
      sample_valid_in <= 1'b1;
      sample_chan_in <= c;
      sample_data_in <= d;
      @(posedge clk_in);
      sample_valid_in <= 1'b0;
    end
  endtask
  task automatic run_scan;
    begin
      @(negedge clk_in);
      while (scan_active_out !== 1'b1)
        @(negedge clk_in);
      repeat (1000) @(posedge clk_in);
    end
  endtask
  task automatic end_scan;
    begin
      @(posedge clk_in);
      scan_done_in <= 1'b1;
      @(posedge clk_in);
      scan_done_in <= 1'b0;
      repeat (3) @(negedge clk_in);
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    begin
      rd(`OFS_TOP_CELL, 32'h0000000d);
      rd(`OFS_HIGH_THR, 32'h00003fff);
      xfer(1'b0, 12'h040, 32'h0);
      chk({63'h0, errq}, 64'h1);
      wr(`OFS_SCAN_CTRL, 32'h00000001);
      repeat (4) @(negedge clk_in);
      chk({63'h0, scan_active_out}, 64'h0);
      $display("test regs done");
    end
  endtask
  task automatic t_odd;
    begin
      wr(`OFS_BAL_SW_EN, 32'h0123);
      wr(`OFS_MEAS_PRIMARY, 32'hffff);
      wr(`OFS_MEAS_AUX, 32'h3f);
      wr(`OFS_DIAG_SEL, 32'hffff);
      wr(`OFS_BIPOLAR, 32'h0010);
      wr(`OFS_TOP_CELL, 32'hb);
      wr(`OFS_LOW_THR, 32'h0100);
      wr(`OFS_IRQ_MASK, 32'h1);
      wr(`OFS_SCAN_CFG, 32'h6);
      wr(`OFS_SCAN_CTRL, 32'h15);
      run_scan();
      chk(eff, {7'h0, 16'h0545, 16'h0, 6'h0, 14'h0545, 1'b1, 3'h0, 1'b1});
      smp(4'h0, 14'h0050);
      smp(4'h1, 14'h0000);
      smp(4'h2, 14'h0500);
      smp(4'h6, 14'h3fff);
      end_scan();
      chk(eff, {7'h0, 16'hffff, 16'hffff, 6'h3f, 14'h0123, 1'b0, 3'h5, 1'b0});
      rd(`OFS_RESULT, 32'h2000);
      rd(`OFS_ALERT, 32'h0001);
      chk({63'h0, irq_out}, 64'h1);
      wr(`OFS_IRQ_STATUS, 32'h3);
      repeat (2) @(negedge clk_in);
      chk({63'h0, irq_out}, 64'h0);
      $display("test odd done");
    end
  endtask
  task automatic t_even;
    begin
      wr(`OFS_IRQ_MASK, 32'h0);
      wr(`OFS_BIPOLAR, 32'h0002);
      wr(`OFS_TOP_CELL, 32'hd);
      wr(`OFS_SCAN_CFG, 32'h7);
      wr(`OFS_SCAN_CTRL, 32'h01);
      run_scan();
      chk(eff, {7'h0, 16'h2aa8, 16'h0, 6'h0, 14'h2aa8, 1'b1, 3'h0, 1'b1});
      smp(4'h1, 14'h0000);
      smp(4'h0, 14'h0000);
      smp(4'h3, 14'h0000);
      smp(4'hd, 14'h3000);
      end_scan();
      rd(`OFS_ALERT, 32'h0009);
      chk({63'h0, irq_out}, 64'h0);
      wr(`OFS_IRQ_MASK, 32'h1);
      repeat (2) @(negedge clk_in);
      chk({63'h0, irq_out}, 64'h1);
      wr(`OFS_ALERT, 32'h9);
      rd(`OFS_ALERT, 32'h0);
      $display("test even done");
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_regs();
    t_odd();
    t_even();
    close_out();
  end
endmodule
`default_nettype wire

// ### swo_diag_defs.vh
`ifndef SWO_DIAG_DEFS_VH
`define SWO_DIAG_DEFS_VH

// APB register byte offsets
`define OFS_BAL_SW_EN      12'h000
`define OFS_MEAS_PRIMARY   12'h004
`define OFS_MEAS_AUX       12'h008
`define OFS_DIAG_SEL       12'h00c
`define OFS_SCAN_CTRL      12'h010
`define OFS_SCAN_CFG       12'h014
`define OFS_BIPOLAR        12'h018
`define OFS_TOP_CELL       12'h01c
`define OFS_LOW_THR        12'h020
`define OFS_HIGH_THR       12'h024
`define OFS_ALERT          12'h028
`define OFS_RESULT         12'h02c
`define OFS_IRQ_STATUS     12'h030
`define OFS_IRQ_MASK       12'h034
`define OFS_EFFECTIVE      12'h038
`define OFS_EFF_SCAN       12'h03c

// Scan modes in scan_config_select
`define SCAN_ODD_OPEN      3'h6
`define SCAN_EVEN_OPEN     3'h7

// Forced switch patterns
`define PAT_ODD            14'h1555
`define PAT_EVEN           14'h2aaa

// scan_control fields
`define SCTRL_START_BIT    0
`define SCTRL_ALT_BIT      1
`define SCTRL_OVS_LSB      2
`define SCTRL_OVS_MSB      4

// Result saturation: 2.5 V in 14-bit code at 5 V full scale
`define RESULT_MAX         14'h2000

// Reset values
`define RST_TOP_CELL       4'hd
`define RST_HIGH_THR       14'h3fff

// Interrupt status bits
`define IRQ_DONE_BIT       0
`define IRQ_ALERT_BIT      1

`endif
